// File: core/smc_pkg.sv
// Constants and types shared by the sleep mode controller
package smc_pkg;
    // Sleep level field encoding
    localparam logic [1:0] LEVEL_IDLE    = 2'h2;
    localparam logic [1:0] LEVEL_STANDBY = 2'h3;
    localparam int         LEVEL_W       = 2;
    // Regulator select field encoding for standby
    localparam logic [1:0] REG_AUTO      = 2'h0;
    localparam logic [1:0] REG_MAIN      = 2'h1;
    localparam logic [1:0] REG_LOWPWR    = 2'h2;
    localparam int         REG_W         = 2;
    // Default clock, oscillator and peripheral counts
    localparam int         NUM_OSC       = 4;
    localparam int         NUM_GENERIC_CLOCK_UNIT      = 8;
    localparam int         NUM_PERIPH    = 8;
    // Wake restore settle time before the core may resume
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         SETTLE_NS     = 40;
    localparam int         SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         CNT_W         = 4;

    typedef enum logic [1:0] {
        SMC_ACTIVE,
        SMC_IDLE,
        SMC_STANDBY,
        SMC_WAKE
    } smc_state_type;
endpackage

// File: core/smc_sleep_ctrl.sv
// Sleep mode controller: entry, clock gating, regulator and RAM bias, wake
`timescale 1ns/1ps
module smc_sleep_ctrl #(
    parameter int NUM_OSC    = smc_pkg::NUM_OSC,
    parameter int NUM_GENERIC_CLOCK_UNIT   = smc_pkg::NUM_GENERIC_CLOCK_UNIT,
    parameter int NUM_PERIPH = smc_pkg::NUM_PERIPH
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic                    wait_for_interrupt_instr,
    input  wire logic                    handler_return,
    input  wire logic                    sleep_after_handler_bit,
    input  wire logic [1:0]              sleep_level_field,
    input  wire logic [1:0]              regulator_select_field,
    input  wire logic                    ram_back_bias_bit,
    input  wire logic                    async_irq,
    input  wire logic [NUM_PERIPH-1:0]   sync_irq,
    input  wire logic [NUM_PERIPH-1:0]   periph_run_in_standby,
    input  wire logic                    sleepwalk_req,
    input  wire logic [NUM_GENERIC_CLOCK_UNIT-1:0]     generic_clock_unit_request,
    input  wire logic [NUM_OSC-1:0]      osc_request,
    input  wire logic [NUM_OSC-1:0]      clock_on_request_bit,
    input  wire logic [NUM_OSC-1:0]      keep_running_low_power_bit,
    input  wire logic                    high_speed_bus_clock_mask,
    input  wire logic                    peripheral_bus_clock_mask,
    output logic                         cpu_clk_en,
    output logic                         ahb_clk_en,
    output logic                         apb_clk_en,
    output logic                         generic_clock_unit_ctrl_clk_en,
    output logic [NUM_GENERIC_CLOCK_UNIT-1:0]          generic_clock_unit_en,
    output logic [NUM_OSC-1:0]           osc_en,
    output logic                         periph_halt,
    output logic                         low_power_regulator,
    output logic                         ram_low_power,
    output logic                         core_resume,
    output logic [1:0]                   sleep_state
);
    // Reset release sync; the controller itself has no disable
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Sequencer state, settle counter and registered outputs
    smc_pkg::smc_state_type    state_reg,  state_next;
    logic [smc_pkg::CNT_W-1:0] cnt_reg,    cnt_next;
    logic                      cpu_reg,    cpu_next;
    logic                      ahb_reg,    ahb_next;
    logic                      apb_reg,    apb_next;
    logic                      gctl_reg,   gctl_next;
    logic                      halt_reg,   halt_next;
    logic                      lpreg_reg,  lpreg_next;
    logic                      ram_reg,    ram_next;
    logic                      resume_reg, resume_next;
    logic [NUM_GENERIC_CLOCK_UNIT-1:0]       generic_clock_unit_reg,   generic_clock_unit_next;
    logic [NUM_OSC-1:0]        osc_reg,    osc_next;
    logic                      sleep_req;
    logic                      sync_wake_idle;
    logic                      sync_wake_stby;

    // Sleep entry request, direct or on handler return
    assign sleep_req = wait_for_interrupt_instr
                     | (handler_return & sleep_after_handler_bit);
    assign sync_wake_idle = |sync_irq;
    // Only peripherals kept running may wake standby synchronously; async_irq wakes it regardless
    assign sync_wake_stby = |(sync_irq & periph_run_in_standby);

    // Oscillator run policy shared by both sleep levels
    function automatic logic [NUM_OSC-1:0] osc_policy(
        input logic               deep,
        input logic [NUM_OSC-1:0] on_req,
        input logic [NUM_OSC-1:0] req,
        input logic [NUM_OSC-1:0] keep_run
    );
        // On-demand oscillators only ever follow their request
        if (deep)
            return req | (~on_req & keep_run);
        return ~on_req | req;
    endfunction

    // State and output next values
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        resume_next = 1'b0;
        unique case (state_reg)
            smc_pkg::SMC_ACTIVE: begin
                if (sleep_req) begin
                    // Handler return without a sleep instruction idles; unknown level codes idle too
                    if (wait_for_interrupt_instr
                        && sleep_level_field == smc_pkg::LEVEL_STANDBY)
                        state_next = smc_pkg::SMC_STANDBY;
                    else
                        state_next = smc_pkg::SMC_IDLE;
                end
            end
            smc_pkg::SMC_IDLE: begin
                if (async_irq || sync_wake_idle) begin
                    state_next = smc_pkg::SMC_WAKE;
                    cnt_next   = '0;
                end
            end
            smc_pkg::SMC_STANDBY: begin
                if (async_irq || sync_wake_stby) begin
                    state_next = smc_pkg::SMC_WAKE;
                    cnt_next   = '0;
                end
            end
            smc_pkg::SMC_WAKE: begin
                // Hold the core until clocks and supply have settled
                if (cnt_reg == smc_pkg::CNT_W'(smc_pkg::SETTLE_CYC - 1)) begin
                    state_next  = smc_pkg::SMC_ACTIVE;
                    resume_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
        endcase

        // Gating follows the next state so outputs change with it
        cpu_next   = 1'b1;
        ahb_next   = 1'b1;
        apb_next   = 1'b1;
        gctl_next  = 1'b1;
        halt_next  = 1'b0;
        lpreg_next = 1'b0;
        ram_next   = 1'b0;
        generic_clock_unit_next  = '1;
        osc_next   = '1;
        unique case (state_next)
            smc_pkg::SMC_IDLE: begin
                cpu_next  = 1'b0;
                ahb_next  = sleepwalk_req;
                apb_next  = sleepwalk_req;
                gctl_next = 1'b1;
                halt_next = 1'b1;
                generic_clock_unit_next = generic_clock_unit_request;
                // Free-running oscillators keep going in idle
                osc_next  = osc_policy(1'b0, clock_on_request_bit,
                                       osc_request, keep_running_low_power_bit);
                lpreg_next = 1'b0;
                ram_next  = 1'b0;
            end
            smc_pkg::SMC_STANDBY: begin
                cpu_next  = 1'b0;
                ahb_next  = sleepwalk_req;
                apb_next  = sleepwalk_req;
                gctl_next = 1'b0;
                halt_next = 1'b1;
                generic_clock_unit_next = sleepwalk_req ? generic_clock_unit_request : '0;
                osc_next  = osc_policy(1'b1, clock_on_request_bit,
                                       osc_request, keep_running_low_power_bit);
                lpreg_next = (regulator_select_field != smc_pkg::REG_MAIN);
                ram_next  = ram_back_bias_bit;
            end
            smc_pkg::SMC_ACTIVE, smc_pkg::SMC_WAKE: begin
                // Active and wake: bus masks rule, full supply
                ahb_next  = high_speed_bus_clock_mask;
                apb_next  = peripheral_bus_clock_mask;
            end
        endcase
    end

    // Registered state and outputs; reset only restarts the sequence
    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg  <= smc_pkg::SMC_ACTIVE;
            cnt_reg    <= '0;
            cpu_reg    <= 1'b1;
            ahb_reg    <= 1'b1;
            apb_reg    <= 1'b1;
            gctl_reg   <= 1'b1;
            halt_reg   <= 1'b0;
            lpreg_reg  <= 1'b0;
            ram_reg    <= 1'b0;
            resume_reg <= 1'b0;
            generic_clock_unit_reg   <= '1;
            osc_reg    <= '1;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            cpu_reg    <= cpu_next;
            ahb_reg    <= ahb_next;
            apb_reg    <= apb_next;
            gctl_reg   <= gctl_next;
            halt_reg   <= halt_next;
            lpreg_reg  <= lpreg_next;
            ram_reg    <= ram_next;
            resume_reg <= resume_next;
            generic_clock_unit_reg   <= generic_clock_unit_next;
            osc_reg    <= osc_next;
        end
    end

    assign cpu_clk_en          = cpu_reg;
    assign ahb_clk_en          = ahb_reg;
    assign apb_clk_en          = apb_reg;
    assign generic_clock_unit_ctrl_clk_en    = gctl_reg;
    assign generic_clock_unit_en             = generic_clock_unit_reg;
    assign osc_en              = osc_reg;
    assign periph_halt         = halt_reg;
    assign low_power_regulator = lpreg_reg;
    assign ram_low_power       = ram_reg;
    assign core_resume         = resume_reg;
    assign sleep_state         = state_reg;
endmodule

// File: test/smc_sleep_ctrl_checker.sv
// Assertions on the sleep mode controller ports
`timescale 1ns/1ps
module smc_sleep_ctrl_checker #(
    parameter int NUM_OSC    = 4,
    parameter int NUM_GENERIC_CLOCK_UNIT   = 8,
    parameter int NUM_PERIPH = 8
) (
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    input wire logic                  wait_for_interrupt_instr,
    input wire logic                  handler_return,
    input wire logic                  sleep_after_handler_bit,
    input wire logic [1:0]            sleep_level_field,
    input wire logic                  async_irq,
    input wire logic [NUM_PERIPH-1:0] sync_irq,
    input wire logic [NUM_PERIPH-1:0] periph_run_in_standby,
    input wire logic                  sleepwalk_req,
    input wire logic [NUM_GENERIC_CLOCK_UNIT-1:0]   generic_clock_unit_request,
    input wire logic [NUM_OSC-1:0]    osc_request,
    input wire logic [NUM_OSC-1:0]    clock_on_request_bit,
    input wire logic [NUM_OSC-1:0]    keep_running_low_power_bit,
    input wire logic                  high_speed_bus_clock_mask,
    input wire logic                  peripheral_bus_clock_mask,
    input wire logic                  cpu_clk_en,
    input wire logic                  ahb_clk_en,
    input wire logic                  apb_clk_en,
    input wire logic                  generic_clock_unit_ctrl_clk_en,
    input wire logic [NUM_GENERIC_CLOCK_UNIT-1:0]   generic_clock_unit_en,
    input wire logic [NUM_OSC-1:0]    osc_en,
    input wire logic                  periph_halt,
    input wire logic                  core_resume,
    input wire logic [1:0]            sleep_state
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // States: 0 active, 1 idle, 2 standby, 3 wake settle
    deep_entry_a: assert property (sleep_state == 2'h0 && wait_for_interrupt_instr
        && sleep_level_field == 2'h3 |=> sleep_state == 2'h2) else $error("no standby");
    idle_entry_a: assert property (sleep_state == 2'h0 && wait_for_interrupt_instr
        && sleep_level_field != 2'h3 |=> sleep_state == 2'h1) else $error("no idle");
    idle_wake_a: assert property (sleep_state == 2'h1 && (async_irq || |sync_irq)
        |=> sleep_state == 2'h3) else $error("idle wake");
    deep_wake_a: assert property (sleep_state == 2'h2 |=> (sleep_state == 2'h3) ==
        ($past(async_irq) || |($past(sync_irq) & $past(periph_run_in_standby))))
        else $error("standby wake");
    clock_stop_a: assert property (sleep_state inside {2'h1, 2'h2}
        |-> !cpu_clk_en && periph_halt) else $error("cpu clock or halt");
    gen_ctrl_a: assert property (sleep_state inside {2'h1, 2'h2}
        |-> generic_clock_unit_ctrl_clk_en == (sleep_state == 2'h1)) else $error("generic control clock");
    walk_clock_a: assert property (sleep_state inside {2'h1, 2'h2} && $stable(sleep_state)
        |-> ahb_clk_en == $past(sleepwalk_req) && apb_clk_en == $past(sleepwalk_req))
        else $error("sleepwalk clock");
    wake_settle_a: assert property ($rose(sleep_state == 2'h3) |-> ##4 sleep_state == 2'h0
        && core_resume && cpu_clk_en && !periph_halt) else $error("wake restore");
    handler_idle_a: assert property (sleep_state == 2'h0 && handler_return
        && sleep_after_handler_bit && !wait_for_interrupt_instr |=> sleep_state == 2'h1)
        else $error("handler return idle");
    bus_mask_a: assert property (sleep_state inside {2'h0, 2'h3}
        |-> ahb_clk_en == $past(high_speed_bus_clock_mask)
        && apb_clk_en == $past(peripheral_bus_clock_mask)) else $error("active bus clocks");
    idle_generic_clock_unit_a: assert property (sleep_state == 2'h1 && $stable(sleep_state)
        |-> generic_clock_unit_en == $past(generic_clock_unit_request)) else $error("idle generic clocks");
    deep_generic_clock_unit_a: assert property (sleep_state == 2'h2 && $stable(sleep_state)
        |-> generic_clock_unit_en == ($past(sleepwalk_req) ? $past(generic_clock_unit_request) : {NUM_GENERIC_CLOCK_UNIT{1'b0}}))
        else $error("standby generic clocks");
    idle_osc_a: assert property (sleep_state == 2'h1 && $stable(sleep_state)
        |-> osc_en == (~$past(clock_on_request_bit) | $past(osc_request)))
        else $error("idle oscillators");
    deep_osc_a: assert property (sleep_state == 2'h2 && $stable(sleep_state)
        |-> osc_en == ($past(osc_request)
        | (~$past(clock_on_request_bit) & $past(keep_running_low_power_bit))))
        else $error("standby oscillators");
    // Main paths the bench must reach
    handler_seen_c: cover property (sleep_state == 2'h0 && handler_return ##1 sleep_state == 2'h1);
    deep_seen_c: cover property (sleep_state == 2'h2 ##1 sleep_state == 2'h3);
    idle_seen_c: cover property (sleep_state == 2'h1 ##1 sleep_state == 2'h3);
    refuse_seen_c: cover property (sleep_state == 2'h2 && |sync_irq ##1 sleep_state == 2'h2);
endmodule
bind smc_sleep_ctrl smc_sleep_ctrl_checker #(
    .NUM_OSC    (NUM_OSC),
    .NUM_GENERIC_CLOCK_UNIT   (NUM_GENERIC_CLOCK_UNIT),
    .NUM_PERIPH (NUM_PERIPH)
) i_smc_sleep_ctrl_checker (.*);

// File: test/smc_core_model.sv
// Core model: bridged sleep level store and sleep instruction issue
`timescale 1ns/1ps
module smc_core_model (
    input  wire logic  core_clk,
    output logic [1:0] sleep_level_field        = 2'h2,
    output logic       wait_for_interrupt_instr = 1'b0,
    output logic       handler_return           = 1'b0
);
    logic [1:0] sleep_config_reg = 2'h2;
    logic [1:0] bridge_reg = 2'h2;
    // Store lands two cycles late, so software must poll before sleeping
    always @(posedge core_clk) {sleep_level_field, bridge_reg} <= {bridge_reg, sleep_config_reg};
    // Write the level, wait for readback, then issue a one-cycle request
    task automatic go_sleep(input logic [1:0] lvl, input logic on_ret);
        sleep_config_reg <= lvl;
        for (int n = 0; n < 8 && sleep_level_field !== lvl; n++) @(posedge core_clk);
        {wait_for_interrupt_instr, handler_return} <= {!on_ret, on_ret};
        @(posedge core_clk);
        {wait_for_interrupt_instr, handler_return} <= 2'h0;
    endtask
endmodule

// File: test/tb.sv
// Self-checking bench of the sleep mode controller with a core model
`timescale 1ns/1ps
module tb;
    logic        core_clk = 1'b0, rst_n = 1'b0, sleep_after_handler_bit = 1'b0;
    logic        ram_back_bias_bit = 1'b0, async_irq = 1'b0, sleepwalk_req = 1'b0;
    logic        high_speed_bus_clock_mask = 1'b1, peripheral_bus_clock_mask = 1'b1;
    logic [1:0]  regulator_select_field = 2'h0, sleep_level_field, sleep_state, last_state = 2'h0;
    logic [7:0]  sync_irq = 8'h00, periph_run_in_standby = 8'h00, generic_clock_unit_request = 8'h00, generic_clock_unit_en;
    logic [3:0]  osc_request = 4'h0, clock_on_request_bit = 4'h0, osc_en;
    logic [3:0]  keep_running_low_power_bit = 4'h0;
    logic        wait_for_interrupt_instr, handler_return, cpu_clk_en, ahb_clk_en, apb_clk_en;
    logic        generic_clock_unit_ctrl_clk_en, periph_halt, low_power_regulator, ram_low_power, core_resume;
    logic [31:0] seed = 32'h27D9;
    logic [7:0]  exp_q[$];
    int          n_errors = 0, total_checks = 0, cycles = 0;

    always #5 core_clk = ~core_clk;
    smc_core_model i_smc_core_model (.*);
    smc_sleep_ctrl i_smc_sleep_ctrl (.*);

    // Xorshift source; fixed start keeps runs repeatable
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Each settled change to a non-wake state retires the oldest note
    // Falling edge: outputs launched on the rising edge have settled
    always @(negedge core_clk) begin
        cycles <= cycles + 1;
        last_state <= sleep_state;
        if (sleep_state !== last_state && sleep_state !== 2'h3)
            chk("outputs", exp_q.size() ? exp_q.pop_front() : 8'hFF, {sleep_state,
                cpu_clk_en, generic_clock_unit_ctrl_clk_en, periph_halt, low_power_regulator, ram_low_power,
                core_resume});
        if (cycles > 3000) begin
            n_errors++;
            end_of_test();
        end
    end

    // Random rounds: all level codes, both entries, refused then accepted wakes
    initial begin
        logic [31:0] r;
        logic        deep;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            deep = r[1:0] == 2'h3 && !(r[2] && r[30]);
            {regulator_select_field, ram_back_bias_bit, sleep_after_handler_bit} <= r[5:2];
            {high_speed_bus_clock_mask, peripheral_bus_clock_mask, sleepwalk_req} <= r[8:6];
            {generic_clock_unit_request, osc_request, clock_on_request_bit, keep_running_low_power_bit} <= r[27:8];
            periph_run_in_standby <= {r[31:26], 2'h2};
            exp_q.push_back({deep ? 2'h2 : 2'h1, 1'b0, !deep, 1'b1, deep && r[5:4] != 2'h1,
                deep && r[3], 1'b0});
            i_smc_core_model.go_sleep(r[1:0], r[2] && r[30]);
            sync_irq <= {7'h00, deep};
            repeat (4) @(posedge core_clk);
            chk("level", {6'h00, deep ? 2'h2 : 2'h1}, {6'h00, sleep_state});
            exp_q.push_back(8'h31);
            {async_irq, sync_irq} <= r[29] ? 9'h100 : 9'h002;
            for (int n = 0; n < 20 && core_resume !== 1'b1; n++) @(posedge core_clk);
            {async_irq, sync_irq, sleepwalk_req} <= 10'h000;
            @(posedge core_clk);
        end
        chk("notes left", 8'h00, 8'(exp_q.size()));
        end_of_test();
    end
endmodule
